/* hdl/rpm_datapath.sv */
// Notes on behaviour
// - two 16-bit sigma-delta channels, modulator rate near 900 kHz, feed the datapath
// - gain bits 00,01,10,11 select current gain 1,2,8,16
// - enabled high-pass filter strips dc from current before multiplication
// - power sample is current sample times matching voltage sample
// - low-pass filter of power stream gives real power
// - low-rate pulses come from long accumulation of real power
// - calibration pulse comes from short accumulation, higher rate
// - datapath timed from 3.5795 MHz master clock, 14 kHz bandwidth
// - high-pass select pin high enables filter, low bypasses it
// - phase compensation active only while high-pass filter enabled
// - calibration rate at most 2048 times low-rate pulse rate
// - reverse flag follows power sign, updated only with a calibration pulse
`timescale 1ns/1ps
`default_nettype none
module rpm_datapath import rpm_pkg::*; #(
    parameter int unsigned CF_PER_F = CF_PER_F_MAX,
    parameter int unsigned CF_WIDTH_CYC = CF_WIDTH,
    parameter int unsigned F_WIDTH_CYC = F_WIDTH,
    parameter logic [ACC_W-1:0] CF_THRESHOLD = CF_THRESH,
    parameter int unsigned FIFO_DEPTH = BUF_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic current_mod_bit_i,
    input wire logic voltage_mod_bit_i,
    input wire logic gain_select_high_i,
    input wire logic gain_select_low_i,
    input wire logic highpass_select_pin_i,
    output logic calibration_pulse_out_o,
    output logic low_rate_pulse_a_o,
    output logic low_rate_pulse_b_o,
    output logic reverse_power_flag_o,
    output logic [PROD_W-1:0] real_power_o
);
    // out-of-range ratios fall back to the widest one
    localparam int unsigned CF_DIV = (CF_PER_F == 0 || CF_PER_F > CF_PER_F_MAX) ?
        CF_PER_F_MAX : CF_PER_F;
    localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [DEC_W-1:0] DEC_MID = DEC_W'(1 << (2 * DECIM_LOG2 - 1));

    // clip a wide value into the signed sample range
    function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [WIDE_W-1:0] v);
        logic signed [WIDE_W-1:0] hi;
        logic signed [WIDE_W-1:0] lo;
        hi = WIDE_W'(2 ** (SAMPLE_W - 1) - 1);
        lo = -hi - WIDE_W'(1);
        if (v > hi) begin
            sat16 = hi[SAMPLE_W-1:0];
        end else if (v < lo) begin
            sat16 = lo[SAMPLE_W-1:0];
        end else begin
            sat16 = v[SAMPLE_W-1:0];
        end
    endfunction

    // master clock enable from a phase accumulator, then modulator and output rates
    logic [PHASE_W-1:0] mclk_phase_reg;
    logic [1:0] mod_cnt_reg;
    logic [DECIM_LOG2-1:0] dec_cnt_reg;
    wire [PHASE_W-1:0] mclk_phase_sum = mclk_phase_reg + PHASE_W'(MCLK_HZ);
    wire mclk_tick = mclk_phase_sum >= PHASE_W'(CLK_HZ);
    wire mod_tick = mclk_tick && (mod_cnt_reg == 2'(MCLK_PER_MOD - 1));
    // the first sample after reset holds a start-up transient of the combs
    wire dump = mod_tick && (dec_cnt_reg == {DECIM_LOG2{1'b1}});

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mclk_phase_reg <= '0;
            mod_cnt_reg <= 2'h0;
            dec_cnt_reg <= '0;
        end else begin
            mclk_phase_reg <= mclk_tick ? mclk_phase_sum - PHASE_W'(CLK_HZ) : mclk_phase_sum;
            if (mclk_tick) begin
                mod_cnt_reg <= mod_tick ? 2'h0 : mod_cnt_reg + 2'h1;
            end
            if (mod_tick) begin
                dec_cnt_reg <= dec_cnt_reg + DECIM_LOG2'(1);
            end
        end
    end

    // second-order comb decimation of both modulator streams
    wire [1:0] mod_bits = {voltage_mod_bit_i, current_mod_bit_i};
    logic signed [SAMPLE_W-1:0] chan_sample [2];
    logic dec_valid_reg;

    for (genvar ch = 0; ch < 2; ch++) begin : g_dec
        logic [DEC_W-1:0] int1_reg;
        logic [DEC_W-1:0] int2_reg;
        logic [DEC_W-1:0] int2_last_reg;
        logic [DEC_W-1:0] comb1_last_reg;
        logic signed [SAMPLE_W-1:0] samp_reg;
        wire [DEC_W-1:0] int1_next = int1_reg + DEC_W'(mod_bits[ch]);
        wire [DEC_W-1:0] int2_next = int2_reg + int1_next;
        wire [DEC_W-1:0] comb1 = int2_next - int2_last_reg;
        wire [DEC_W-1:0] comb2 = comb1 - comb1_last_reg;
        wire [DEC_W-1:0] centred = comb2 - DEC_MID;
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                int1_reg <= '0;
                int2_reg <= '0;
                int2_last_reg <= '0;
                comb1_last_reg <= '0;
                samp_reg <= '0;
            end else if (mod_tick) begin
                int1_reg <= int1_next;
                int2_reg <= int2_next;
                if (dump) begin
                    int2_last_reg <= int2_next;
                    comb1_last_reg <= comb1;
                    samp_reg <= {centred[SAMPLE_W-4:0], 3'h0};
                end
            end
        end
        assign chan_sample[ch] = samp_reg;
    end

    // current gain, high-pass filter and phase compensation
    wire [1:0] gain_code = {gain_select_high_i, gain_select_low_i};
    wire [2:0] gain_shift = (gain_code == GAIN_CODE_X1) ? GAIN_SHIFT_X1 :
        (gain_code == GAIN_CODE_X2) ? GAIN_SHIFT_X2 :
        (gain_code == GAIN_CODE_X8) ? GAIN_SHIFT_X8 : GAIN_SHIFT_X16;
    wire signed [WIDE_W-1:0] cur_wide = WIDE_W'(chan_sample[0]) <<< gain_shift;
    wire signed [SAMPLE_W-1:0] cur_gain = sat16(cur_wide);

    logic signed [SAMPLE_W-1:0] x_last_reg;
    logic signed [WIDE_W-1:0] hpf_reg;
    logic signed [SAMPLE_W-1:0] hp_last_reg;
    logic signed [SAMPLE_W-1:0] cur_s_reg;
    logic signed [SAMPLE_W-1:0] volt_s_reg;
    logic s1_valid_reg;
    wire signed [WIDE_W-1:0] hpf_next = hpf_reg + WIDE_W'(cur_gain) - WIDE_W'(x_last_reg)
        - (hpf_reg >>> HPF_SHIFT);
    wire signed [SAMPLE_W-1:0] hpf_out = sat16(hpf_next);
    wire signed [WIDE_W-1:0] hp_delta = WIDE_W'(hpf_out) - WIDE_W'(hp_last_reg);
    wire signed [SAMPLE_W-1:0] comp_out = sat16(WIDE_W'(hpf_out) - (hp_delta >>> PHASE_SHIFT));
    wire signed [SAMPLE_W-1:0] cur_sel = highpass_select_pin_i ? comp_out : cur_gain;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dec_valid_reg <= 1'b0;
            x_last_reg <= '0;
            hpf_reg <= '0;
            hp_last_reg <= '0;
            cur_s_reg <= '0;
            volt_s_reg <= '0;
            s1_valid_reg <= 1'b0;
        end else begin
            dec_valid_reg <= dump;
            s1_valid_reg <= dec_valid_reg;
            if (dec_valid_reg) begin
                x_last_reg <= cur_gain;
                hpf_reg <= hpf_next;
                hp_last_reg <= hpf_out;
                cur_s_reg <= cur_sel;
                volt_s_reg <= chan_sample[1];
            end
        end
    end

    // multiplication and low-pass filter
    logic signed [PROD_W-1:0] prod_reg;
    logic prod_valid_reg;
    logic signed [PROD_W-1:0] lpf_reg;
    logic buf_in_ready;
    // a product that meets a full buffer waits, and the next one overwrites it
    wire lpf_take = prod_valid_reg && buf_in_ready;
    wire signed [PROD_W:0] lpf_diff = (PROD_W + 1)'(prod_reg) - (PROD_W + 1)'(lpf_reg);
    wire signed [PROD_W-1:0] lpf_next = lpf_reg + PROD_W'(lpf_diff >>> LPF_SHIFT);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prod_reg <= '0;
            prod_valid_reg <= 1'b0;
            lpf_reg <= '0;
        end else begin
            if (s1_valid_reg) begin
                prod_reg <= cur_s_reg * volt_s_reg;
            end
            prod_valid_reg <= s1_valid_reg || (prod_valid_reg && !lpf_take);
            if (lpf_take) begin
                lpf_reg <= lpf_next;
            end
        end
    end
    assign real_power_o = lpf_reg;

    // two-entry buffer between filter and frequency converter
    logic [PROD_W-1:0] buf_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] buf_cnt_reg;
    logic dfc_ready;
    assign buf_in_ready = buf_cnt_reg != CNT_W'(FIFO_DEPTH);
    wire buf_out_valid = buf_cnt_reg != '0;
    wire buf_pop = buf_out_valid && dfc_ready;
    wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 :
        wr_ptr_reg + PTR_W'(1);
    wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 :
        rd_ptr_reg + PTR_W'(1);

    always_ff @(posedge clk_sys_i) begin
        if (lpf_take) begin
            buf_mem[wr_ptr_reg] <= lpf_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            buf_cnt_reg <= '0;
        end else begin
            if (lpf_take) begin
                wr_ptr_reg <= wr_ptr_inc;
            end
            if (buf_pop) begin
                rd_ptr_reg <= rd_ptr_inc;
            end
            if (lpf_take && !buf_pop) begin
                buf_cnt_reg <= buf_cnt_reg + CNT_W'(1);
            end else if (buf_pop && !lpf_take) begin
                buf_cnt_reg <= buf_cnt_reg - CNT_W'(1);
            end
        end
    end

    // digital-to-frequency conversion
    logic signed [ACC_W-1:0] cf_acc_reg;
    logic [WID_W-1:0] cf_wid_reg;
    logic [WID_W-1:0] f_wid_reg;
    logic [FDIV_W-1:0] f_cnt_reg;
    logic f_sel_reg;
    logic f_side_reg;
    logic cf_out_reg;
    logic f_a_reg;
    logic f_b_reg;
    logic reverse_power_flag_reg;
    wire signed [PROD_W-1:0] buf_word = buf_mem[rd_ptr_reg];
    wire signed [ACC_W-1:0] thr = CF_THRESHOLD;
    wire signed [ACC_W-1:0] acc_sum = cf_acc_reg + ACC_W'(buf_word);
    wire acc_pos = acc_sum >= thr;
    wire acc_neg = acc_sum <= -thr;
    wire cf_fire = buf_pop && (acc_pos || acc_neg);
    // every CF_DIV-th calibration pulse also starts a low-rate pulse
    wire f_fire = cf_fire && (f_cnt_reg == FDIV_W'(CF_DIV - 1));
    // no word is taken while a calibration pulse stands, so pulses never merge
    assign dfc_ready = cf_wid_reg == '0;
    wire [WID_W-1:0] cf_wid_next = cf_fire ? WID_W'(CF_WIDTH_CYC) :
        (cf_wid_reg != '0) ? cf_wid_reg - WID_W'(1) : '0;
    wire [WID_W-1:0] f_wid_next = f_fire ? WID_W'(F_WIDTH_CYC) :
        (f_wid_reg != '0) ? f_wid_reg - WID_W'(1) : '0;
    wire f_side_next = f_fire ? f_sel_reg : f_side_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cf_acc_reg <= '0;
            cf_wid_reg <= '0;
            f_wid_reg <= '0;
            f_cnt_reg <= '0;
            f_sel_reg <= 1'b0;
            f_side_reg <= 1'b0;
            cf_out_reg <= 1'b0;
            f_a_reg <= 1'b0;
            f_b_reg <= 1'b0;
            reverse_power_flag_reg <= 1'b0;
        end else begin
            if (buf_pop) begin
                if (acc_pos) begin
                    cf_acc_reg <= acc_sum - thr;
                    reverse_power_flag_reg <= 1'b0;
                end else if (acc_neg) begin
                    cf_acc_reg <= acc_sum + thr;
                    reverse_power_flag_reg <= 1'b1;
                end else begin
                    cf_acc_reg <= acc_sum;
                end
            end
            if (cf_fire) begin
                f_cnt_reg <= f_fire ? '0 : f_cnt_reg + FDIV_W'(1);
            end
            if (f_fire) begin
                f_sel_reg <= !f_sel_reg;
            end
            cf_wid_reg <= cf_wid_next;
            f_wid_reg <= f_wid_next;
            f_side_reg <= f_side_next;
            cf_out_reg <= cf_wid_next != '0;
            f_a_reg <= (f_wid_next != '0) && !f_side_next;
            f_b_reg <= (f_wid_next != '0) && f_side_next;
        end
    end

    assign calibration_pulse_out_o = cf_out_reg;
    assign low_rate_pulse_a_o = f_a_reg;
    assign low_rate_pulse_b_o = f_b_reg;
    assign reverse_power_flag_o = reverse_power_flag_reg;
endmodule
`default_nettype wire

/* hdl/rpm_datapath_note_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* hdl/rpm_pkg.sv */
`default_nettype none
package rpm_pkg;
    // system clock and the rates derived from it
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MCLK_HZ = 3_579_500;
    localparam int unsigned MOD_HZ = 900_000;
    localparam int unsigned BANDWIDTH_HZ = 14_000;
    localparam int unsigned MCLK_PER_MOD = (MCLK_HZ + MOD_HZ / 2) / MOD_HZ;
    localparam int unsigned PHASE_W = 32;

    // converter and datapath widths
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned DECIM_LOG2 = 6;
    localparam int unsigned DEC_W = 2 * DECIM_LOG2 + 2;
    localparam int unsigned PROD_W = 2 * SAMPLE_W;
    localparam int unsigned ACC_W = 40;
    localparam int unsigned WIDE_W = 24;

    // filter shifts
    localparam int unsigned HPF_SHIFT = 10;
    localparam int unsigned PHASE_SHIFT = 4;
    localparam int unsigned LPF_SHIFT = 8;

    // current gain stage codes and their shifts
    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [1:0] GAIN_CODE_X8 = 2'h2;
    localparam logic [2:0] GAIN_SHIFT_X1 = 3'h0;
    localparam logic [2:0] GAIN_SHIFT_X2 = 3'h1;
    localparam logic [2:0] GAIN_SHIFT_X8 = 3'h3;
    localparam logic [2:0] GAIN_SHIFT_X16 = 3'h4;

    // frequency conversion
    localparam logic [ACC_W-1:0] CF_THRESH = 40'h0040000000;
    localparam int unsigned CF_PER_F_MAX = 2048;
    localparam int unsigned FDIV_W = 12;
    localparam int unsigned CF_WIDTH = 16;
    localparam int unsigned F_WIDTH = 64;
    localparam int unsigned WID_W = 16;

    // output buffer
    localparam int unsigned BUF_DEPTH = 2;
endpackage
`default_nettype wire

/* testbench/rpm_datapath_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rpm_datapath_assertions import rpm_pkg::*; #(
    parameter int unsigned CF_PER_F = CF_PER_F_MAX,
    parameter int unsigned CF_WIDTH_CYC = CF_WIDTH,
    parameter int unsigned F_WIDTH_CYC = F_WIDTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic calibration_pulse_out_o,
    input wire logic low_rate_pulse_a_o,
    input wire logic low_rate_pulse_b_o,
    input wire logic reverse_power_flag_o
);
    wire cal = calibration_pulse_out_o;
    wire lra = low_rate_pulse_a_o;
    wire lrb = low_rate_pulse_b_o;
    wire lrx = lra | lrb;
    int cal_run_reg;
    int lr_run_reg;
    int cal_seen_reg;
    logic next_b_reg;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_run_reg <= 0;
            lr_run_reg <= 0;
            cal_seen_reg <= 0;
            next_b_reg <= 1'b0;
        end else begin
            cal_run_reg <= cal ? cal_run_reg + 1 : 0;
            lr_run_reg <= lrx ? lr_run_reg + 1 : 0;
            if ($rose(cal)) begin
                cal_seen_reg <= ($rose(lra) || $rose(lrb)) ? 0 : cal_seen_reg + 1;
            end
            if ($rose(lra)) begin
                next_b_reg <= 1'b1;
            end else if ($rose(lrb)) begin
                next_b_reg <= 1'b0;
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence cal_start;
        $rose(cal);
    endsequence
    sequence lr_start;
        $rose(lra) || $rose(lrb);
    endsequence
    sequence cal_only;
        $rose(cal) && !$rose(lra) && !$rose(lrb);
    endsequence
    cal_width_a: assert property ($fell(cal) |-> cal_run_reg == CF_WIDTH_CYC)
        else $error("calibration pulse width wrong");
    cal_long_a: assert property (cal |-> cal_run_reg < CF_WIDTH_CYC)
        else $error("calibration pulse too long");
    lr_width_a: assert property ($fell(lrx) |-> lr_run_reg == F_WIDTH_CYC)
        else $error("low rate pulse width wrong");
    lr_sync_a: assert property (lr_start |-> cal_start)
        else $error("low rate pulse without calibration pulse");
    lr_ratio_a: assert property (lr_start |-> cal_seen_reg == CF_PER_F - 1)
        else $error("low rate pulse at wrong count");
    cal_ratio_a: assert property (cal_only |-> cal_seen_reg < CF_PER_F - 1)
        else $error("low rate pulse missing");
    lr_order_a: assert property (lr_start |-> lra != next_b_reg && !(lra && lrb))
        else $error("low rate pulses out of turn");
    rev_sync_a: assert property ($changed(reverse_power_flag_o) |-> cal_start)
        else $error("reverse flag moved without calibration pulse");
    rst_quiet_a: assert property ($rose(nrst_i) |-> !cal && !lrx && !reverse_power_flag_o)
        else $error("outputs active right after reset");
endmodule
`default_nettype wire

/* testbench/rpm_pulse_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module rpm_pulse_counter (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic cal_i,
    input wire logic pa_i,
    input wire logic pb_i,
    output var int cal_cnt_o,
    output var int pa_cnt_o,
    output var int pb_cnt_o
);
    logic [2:0] prev_reg;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_reg <= 3'h0;
            cal_cnt_o <= 0;
            pa_cnt_o <= 0;
            pb_cnt_o <= 0;
        end else begin
            prev_reg <= {cal_i, pa_i, pb_i};
            cal_cnt_o <= cal_cnt_o + int'(cal_i && !prev_reg[2]);
            pa_cnt_o <= pa_cnt_o + int'(pa_i && !prev_reg[1]);
            pb_cnt_o <= pb_cnt_o + int'(pb_i && !prev_reg[0]);
        end
    end
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import rpm_pkg::*;;
    localparam int unsigned NPF = 4;
    localparam int unsigned PH = 15000;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cb = 1'b0;
    logic vb = 1'b0;
    logic gh = 1'b0;
    logic gl = 1'b0;
    logic hp = 1'b0;
    logic cal, pa, pb, rev;
    logic [PROD_W-1:0] rp;
    logic [4:0] dc = 5'h10;
    logic [4:0] dv = 5'h10;
    logic [31:0] lfsr = 32'hd97a;
    int cal_n, pa_n, pb_n;
    int fails = 0;
    int n_compared = 0;
    longint rp_g [4];
    always #25 clk_sys_i = ~clk_sys_i;
    rpm_datapath #(.CF_PER_F(NPF), .CF_WIDTH_CYC(1600), .F_WIDTH_CYC(8),
        .CF_THRESHOLD(40'h0000200000), .FIFO_DEPTH(BUF_DEPTH)) dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .current_mod_bit_i(cb),
        .voltage_mod_bit_i(vb), .gain_select_high_i(gh), .gain_select_low_i(gl),
        .highpass_select_pin_i(hp), .calibration_pulse_out_o(cal),
        .low_rate_pulse_a_o(pa), .low_rate_pulse_b_o(pb),
        .reverse_power_flag_o(rev), .real_power_o(rp));
    rpm_pulse_counter cnt (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cal_i(cal),
        .pa_i(pa), .pb_i(pb), .cal_cnt_o(cal_n), .pa_cnt_o(pa_n), .pb_cnt_o(pb_n));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic exp_neg(input logic [4:0] c, input logic [4:0] v);
        return (c < 5'h08) != (v < 5'h08);
    endfunction
    function automatic longint gain_of(input int g);
        return (g == 0) ? 1 : (g == 1) ? 2 : (g == 2) ? 8 : 16;
    endfunction
    always @(negedge clk_sys_i) begin
        lfsr <= lfsr_next(lfsr);
        cb <= {1'b0, lfsr[3:0]} < dc;
        vb <= {1'b0, lfsr[11:8]} < dv;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic phase(input logic [4:0] c, input logic [4:0] v, input int g, input logic h);
        @(negedge clk_sys_i);
        nrst_i = 1'b0;
        dc = c;
        dv = v;
        {gh, gl} = 2'(g);
        hp = h;
        repeat (8) @(negedge clk_sys_i);
        chk("quiet outputs", 32'({cal, pa, pb, rev}), 32'h0);
        nrst_i = 1'b1;
        repeat (PH) @(negedge clk_sys_i);
        chk("reverse flag", 32'(rev), 32'(exp_neg(c, v)));
        chk("power sign", 32'(rp[PROD_W-1]), 32'(exp_neg(c, v)));
        chk("cal pulses", 32'(cal_n > 0), 32'h1);
        chk("low pulses", 32'(pa_n + pb_n), 32'(cal_n / NPF));
        chk("low order", 32'(pa_n - pb_n), 32'((pa_n + pb_n) % 2));
    endtask
    initial begin
        repeat (6 * (PH + 9) + 1000) @(posedge clk_sys_i);
        fails++;
        test_done();
    end
    initial begin
        for (int g = 0; g < 4; g++) begin
            phase(5'h09, 5'h10, g, g[0]);
            rp_g[g] = longint'($signed(rp));
        end
        for (int g = 1; g < 4; g++)
            chk("gain", 32'(2 * rp_g[g] * gain_of(g - 1) > rp_g[g - 1] * gain_of(g)), 32'h1);
        phase(5'h00, 5'h10, 3, 1'b1);
        phase(5'h10, 5'h00, 0, 1'b0);
        test_done();
    end
endmodule
bind rpm_datapath rpm_datapath_assertions #(.CF_PER_F(CF_PER_F), .CF_WIDTH_CYC(CF_WIDTH_CYC),
    .F_WIDTH_CYC(F_WIDTH_CYC)) u_chk (.clk_sys_i, .nrst_i, .calibration_pulse_out_o,
    .low_rate_pulse_a_o, .low_rate_pulse_b_o, .reverse_power_flag_o);
`default_nettype wire
